// ===== hdl/supply_controller_regs.sv
/*
 Supply controller register block with keyed commands, supply monitor
 sampling, wakeup filtering and tamper clear.
 Assumes synchronous inputs, a slow-clock tick on slow_clock_tick_i and
 a write-protect level from the system controller.
*/
// The address-and-strobe port was chosen for this implementation.
module supply_controller_regs (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic write_protect_enable_i,
	input wire logic slow_clock_tick_i,
	input wire logic monitor_detect_i,
	input wire logic brownout_detect_i,
	input wire logic backup_por_state_i,
	input wire logic force_wake_n_i,
	input wire logic [15:0] wake_pins_i,
	input wire logic rtc_pulse_out_i,
	output supply_pkg::analog_ctl_s analog_ctl_o,
	output logic monitor_enable_o,
	output logic regulator_off_o,
	output logic crystal_select_o,
	output logic backup_por_settled_o,
	output logic system_reset_o,
	output logic irq_o,
	output logic wakeup_o,
	output logic backup_regs_clear_o
);
	logic [31:0] monitor_ff;
	logic [31:0] power_ff;
	logic [31:0] wake_src_ff;
	logic [31:0] wake_pin_ff;
	logic [7:0] status_ff;
	logic [31:0] rdata_ff;
	logic regulator_off_ff;
	logic crystal_ff;
	logic reset_ff;
	logic [10:0] sample_cnt_ff;
	logic monitor_on_ff;
	logic rtc_prev_ff;
	logic [2:0] tmp_cnt_ff;
	logic [3:0] tmp_seen_ff;
	logic clear_ff;
	logic wr_ok;
	logic key_ok;
	logic status_rd;
	logic mon_hit;
	logic bod_hit;
	logic force_fire;
	logic pin_fire;
	logic pin_active;
	logic rtc_sample;
	logic [3:0] tmp_pins;
	logic [3:0] tmp_en;
	logic [3:0] tmp_active;
	logic tmp_fire;
	logic nxt_monitor_on;
	logic [7:0] nxt_status;
	supply_pkg::monitor_mode_e mode;

	// ---------------------------------------------------------------
	// Write qualification
	// ---------------------------------------------------------------
	assign wr_ok = reg_wr_i && !write_protect_enable_i;
	assign key_ok = reg_wdata_i[supply_pkg::KEY_LSB +: 8]
		== supply_pkg::KEY_VALUE;
	assign status_rd = reg_rd_i && reg_addr_i == supply_pkg::OFF_STATUS;

	// Monitor setup register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			monitor_ff <= supply_pkg::RST_MONITOR;
		end else if (wr_ok && reg_addr_i == supply_pkg::OFF_MONITOR) begin
			monitor_ff <= reg_wdata_i & supply_pkg::MASK_MONITOR;
		end
	end

	// Power setup register, keyed; fixed reset bits outside the mask stay
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			power_ff <= supply_pkg::RST_POWER;
		end else if (wr_ok && key_ok
			&& reg_addr_i == supply_pkg::OFF_POWER) begin
			power_ff <= (power_ff & ~supply_pkg::MASK_POWER)
				| (reg_wdata_i & supply_pkg::MASK_POWER);
		end
	end

	// Wakeup source register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_src_ff <= supply_pkg::RST_WAKE_SRC;
		end else if (wr_ok && reg_addr_i == supply_pkg::OFF_WAKE_SRC) begin
			wake_src_ff <= reg_wdata_i & supply_pkg::MASK_WAKE_SRC;
		end
	end

	// Wakeup pin register is not covered by write protect
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_pin_ff <= supply_pkg::RST_WAKE_PIN;
		end else if (reg_wr_i && reg_addr_i == supply_pkg::OFF_WAKE_PIN) begin
			wake_pin_ff <= reg_wdata_i;
		end
	end

	// ---------------------------------------------------------------
	// Keyed commands: regulator off and crystal select stick
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			regulator_off_ff <= 1'b0;
			crystal_ff <= 1'b0;
		end else if (wr_ok && key_ok
			&& reg_addr_i == supply_pkg::OFF_COMMAND) begin
			if (reg_wdata_i[supply_pkg::CMD_REG_OFF]) begin
				regulator_off_ff <= 1'b1;
			end
			if (reg_wdata_i[supply_pkg::CMD_XTAL]) begin
				crystal_ff <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Supply monitor sampling window
	// ---------------------------------------------------------------
	assign mode = supply_pkg::monitor_mode_e'(
		monitor_ff[supply_pkg::MON_SMPL_LSB +: 3]);

	always_comb begin
		case (mode)
			supply_pkg::MON_CONT: nxt_monitor_on = 1'b1;
			supply_pkg::MON_32: nxt_monitor_on =
				(sample_cnt_ff & supply_pkg::MON_MASK_32) == 11'h000;
			supply_pkg::MON_256: nxt_monitor_on =
				(sample_cnt_ff & supply_pkg::MON_MASK_256) == 11'h000;
			supply_pkg::MON_2048: nxt_monitor_on =
				(sample_cnt_ff & supply_pkg::MON_MASK_2048) == 11'h000;
			default: nxt_monitor_on = 1'b0;
		endcase
	end

	// Slow-period counter and window flop, one window per period
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sample_cnt_ff <= 11'h000;
			monitor_on_ff <= 1'b0;
		end else if (slow_clock_tick_i) begin
			sample_cnt_ff <= sample_cnt_ff + 11'h001;
			monitor_on_ff <= nxt_monitor_on;
		end else if (mode == supply_pkg::MON_OFF) begin
			monitor_on_ff <= 1'b0;
		end
	end

	assign mon_hit = monitor_on_ff && monitor_detect_i;
	assign bod_hit = brownout_detect_i
		&& !power_ff[supply_pkg::PWR_BOD_DIS];

	// ---------------------------------------------------------------
	// System reset request, one cycle after its cause
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_ff <= 1'b0;
		end else begin
			reset_ff <= (mon_hit && monitor_ff[supply_pkg::MON_RST_EN])
				|| (bod_hit && power_ff[supply_pkg::PWR_BOD_RST])
				|| (wr_ok && key_ok && reg_addr_i == supply_pkg::OFF_COMMAND
				&& reg_wdata_i[supply_pkg::CMD_REG_OFF]);
		end
	end

	// ---------------------------------------------------------------
	// Wakeup inputs
	// ---------------------------------------------------------------
	assign pin_active = |(wake_pin_ff[15:0]
		& ~(wake_pins_i ^ wake_pin_ff[31:16]));

	wake_filter u_force_filter (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.tick_i(slow_clock_tick_i),
		.active_i(!force_wake_n_i
			&& wake_src_ff[supply_pkg::WU_FORCE_EN]),
		.limit_i(supply_pkg::debounce_limit(
			wake_src_ff[supply_pkg::WU_FORCE_DBC +: 3])),
		.fire_o(force_fire)
	);

	wake_filter u_pin_filter (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.tick_i(slow_clock_tick_i),
		.active_i(pin_active),
		.limit_i(supply_pkg::debounce_limit(
			wake_src_ff[supply_pkg::WU_PIN_DBC +: 3])),
		.fire_o(pin_fire)
	);

	// ---------------------------------------------------------------
	// Tamper inputs on wake pins 0, 10, 14 and 15, sampled at the
	// falling edge of the RTC pulse
	// ---------------------------------------------------------------
	assign tmp_pins = {wake_pins_i[15], wake_pins_i[14],
		wake_pins_i[10], wake_pins_i[0]};
	assign tmp_en = {wake_src_ff[21], wake_src_ff[20],
		wake_src_ff[6], wake_src_ff[5]};
	assign tmp_active = tmp_en & ~(tmp_pins ^ {wake_pin_ff[31],
		wake_pin_ff[30], wake_pin_ff[26], wake_pin_ff[16]});
	assign rtc_sample = rtc_prev_ff && !rtc_pulse_out_i;
	assign tmp_cnt_ff = wake_src_ff[supply_pkg::WU_TMP_CNT +: 3];

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rtc_prev_ff <= 1'b0;
		end else begin
			rtc_prev_ff <= rtc_pulse_out_i;
		end
	end

	wake_filter u_tamper_filter (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.tick_i(rtc_sample),
		.active_i(|tmp_active && tmp_cnt_ff != 3'h0),
		.limit_i({13'h0, tmp_cnt_ff} + 16'h0001),
		.fire_o(tmp_fire)
	);

	// Register the active tamper inputs every cycle, one cycle behind, in step with the filter fire
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tmp_seen_ff <= 4'h0;
		end else begin
			tmp_seen_ff <= tmp_active;
		end
	end

	// Immediate clear of the first backup half
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clear_ff <= 1'b0;
		end else begin
			clear_ff <= tmp_fire && wake_src_ff[supply_pkg::WU_TMP_CLR]
				&& |(tmp_seen_ff & {~wake_src_ff[supply_pkg::WU_DIS_CLR +: 3],
				1'b1});
		end
	end

	// ---------------------------------------------------------------
	// Status flags: set wins over clear-on-read
	// ---------------------------------------------------------------
	always_comb begin
		nxt_status = status_rd ? 8'h00 : status_ff;
		nxt_status[supply_pkg::ST_FORCE] = nxt_status[supply_pkg::ST_FORCE]
			| force_fire;
		nxt_status[supply_pkg::ST_MONITOR] =
			nxt_status[supply_pkg::ST_MONITOR] | mon_hit;
		nxt_status[supply_pkg::ST_PIN] = nxt_status[supply_pkg::ST_PIN]
			| pin_fire;
		nxt_status[supply_pkg::ST_BPOR] = 1'b0;
		nxt_status[supply_pkg::ST_TAMPER +: 4] =
			nxt_status[supply_pkg::ST_TAMPER +: 4]
			| (tmp_fire ? tmp_seen_ff : 4'h0);
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_ff <= 8'h00;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ---------------------------------------------------------------
	// Read path, data valid the cycle after the strobe
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				supply_pkg::OFF_MONITOR: rdata_ff <= monitor_ff;
				supply_pkg::OFF_POWER: rdata_ff <= power_ff;
				supply_pkg::OFF_WAKE_SRC: rdata_ff <= wake_src_ff;
				supply_pkg::OFF_WAKE_PIN: rdata_ff <= wake_pin_ff;
				supply_pkg::OFF_STATUS: rdata_ff <= {24'h000000, status_ff[7:4],
					backup_por_state_i, status_ff[2:0]};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o = rdata_ff;
	assign analog_ctl_o.monitor_threshold = monitor_ff[3:0];
	assign analog_ctl_o.lcd_regulator_level = power_ff[3:0];
	assign analog_ctl_o.lcd_supply_select = power_ff[5:4];
	assign analog_ctl_o.brownout_disable = power_ff[supply_pkg::PWR_BOD_DIS];
	assign analog_ctl_o.internal_regulator_used =
		power_ff[supply_pkg::PWR_INTERNAL_REGULATOR_USED];
	assign analog_ctl_o.backup_por_enable = power_ff[supply_pkg::PWR_BPOR];
	assign analog_ctl_o.osc_bypass_a = power_ff[supply_pkg::PWR_BYPASS]
		&& crystal_ff;
	assign backup_por_settled_o = power_ff[supply_pkg::PWR_BPOR]
		== backup_por_state_i;
	assign monitor_enable_o = monitor_on_ff;
	assign regulator_off_o = regulator_off_ff;
	assign crystal_select_o = crystal_ff;
	assign system_reset_o = reset_ff;
	assign irq_o = status_ff[supply_pkg::ST_MONITOR]
		&& monitor_ff[supply_pkg::MON_IRQ_EN];
	assign wakeup_o = force_fire || pin_fire || tmp_fire;
	assign backup_regs_clear_o = clear_ff;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_keyed_cmd(int b);
		wr_ok && key_ok && reg_addr_i == supply_pkg::OFF_COMMAND
			&& reg_wdata_i[b];
	endsequence

	property p_bad_key;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		reg_wr_i && !key_ok && reg_addr_i == supply_pkg::OFF_POWER
			|=> $stable(power_ff);
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("unkeyed write changed power setup");

	property p_protect;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		write_protect_enable_i |=> $stable(monitor_ff)
			&& $stable(wake_src_ff);
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected register changed");

	property p_reg_off;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_keyed_cmd(supply_pkg::CMD_REG_OFF) |=> system_reset_o
			&& regulator_off_o;
	endproperty
	a_reg_off: assert property (p_reg_off)
		else $error("regulator off did not reset");

	property p_xtal;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_keyed_cmd(supply_pkg::CMD_XTAL) |=> crystal_select_o;
	endproperty
	a_xtal: assert property (p_xtal)
		else $error("crystal select not taken");

	property p_mon_off;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		mode == supply_pkg::MON_OFF |=> !monitor_enable_o;
	endproperty
	a_mon_off: assert property (p_mon_off)
		else $error("monitor active while off");

	property p_mon_reset;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		mon_hit && monitor_ff[supply_pkg::MON_RST_EN] |=> system_reset_o;
	endproperty
	a_mon_reset: assert property (p_mon_reset)
		else $error("monitor detection did not reset");

	property p_bod_reset;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		bod_hit && power_ff[supply_pkg::PWR_BOD_RST] |=> system_reset_o;
	endproperty
	a_bod_reset: assert property (p_bod_reset)
		else $error("brownout did not reset");

	property p_mon_irq;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		mon_hit && monitor_ff[supply_pkg::MON_IRQ_EN] |=> irq_o;
	endproperty
	a_mon_irq: assert property (p_mon_irq)
		else $error("monitor interrupt missing");

	property p_force_wake;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		!wake_src_ff[supply_pkg::WU_FORCE_EN] [*2] |-> !force_fire;
	endproperty
	a_force_wake: assert property (p_force_wake)
		else $error("force wake while disabled");

	property p_clear;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		backup_regs_clear_o |-> $past(tmp_fire)
			&& $past(wake_src_ff[supply_pkg::WU_TMP_CLR]);
	endproperty
	a_clear: assert property (p_clear)
		else $error("backup clear without tamper event");
endmodule

// ===== hdl/supply_pkg.sv
/*
 Constants, field layout and carrier types of the supply controller.
 Assumes one 100 MHz system clock and a slow-clock tick pulse.
*/
package supply_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_COMMAND = 8'h00;
	localparam logic [7:0] OFF_MONITOR = 8'h04;
	localparam logic [7:0] OFF_POWER = 8'h08;
	localparam logic [7:0] OFF_WAKE_SRC = 8'h0C;
	localparam logic [7:0] OFF_WAKE_PIN = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [31:0] RST_MONITOR = 32'h0000_0000;
	localparam logic [31:0] RST_POWER = 32'h0000_DA00;
	localparam logic [31:0] RST_WAKE_SRC = 32'h0000_0000;
	localparam logic [31:0] RST_WAKE_PIN = 32'h0000_0000;
	// Writable bits; power keeps the rest, the other registers load zero there
	localparam logic [31:0] MASK_MONITOR = 32'h0000_370F;
	localparam logic [31:0] MASK_POWER = 32'h0010_F03F;
	localparam logic [31:0] MASK_WAKE_SRC = 32'h7737_77EF;
	localparam logic [7:0] KEY_VALUE = 8'hA5;
	localparam int KEY_LSB = 24;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CMD_REG_OFF = 2;
	localparam int CMD_XTAL = 3;
	localparam int MON_SMPL_LSB = 8;
	localparam int MON_RST_EN = 12;
	localparam int MON_IRQ_EN = 13;
	localparam int PWR_BOD_RST = 12;
	localparam int PWR_BOD_DIS = 13;
	localparam int PWR_INTERNAL_REGULATOR_USED = 14;
	localparam int PWR_BPOR = 15;
	localparam int PWR_BYPASS = 20;
	localparam int WU_FORCE_EN = 0;
	localparam int WU_FORCE_DBC = 8;
	localparam int WU_PIN_DBC = 12;
	localparam int WU_TMP_CNT = 16;
	localparam int WU_TMP_CLR = 7;
	localparam int WU_DIS_CLR = 24;
	localparam int ST_FORCE = 0;
	localparam int ST_MONITOR = 1;
	localparam int ST_PIN = 2;
	localparam int ST_BPOR = 3;
	localparam int ST_TAMPER = 4;
	// ---------------------------------------------------------------
	// Counts in slow-clock periods
	// ---------------------------------------------------------------
	localparam logic [15:0] DBC_1 = 16'h0003;
	localparam logic [15:0] DBC_2 = 16'h0020;
	localparam logic [15:0] DBC_3 = 16'h0200;
	localparam logic [15:0] DBC_4 = 16'h1000;
	localparam logic [15:0] DBC_5 = 16'h8000;
	localparam logic [10:0] MON_MASK_32 = 11'h01F;
	localparam logic [10:0] MON_MASK_256 = 11'h0FF;
	localparam logic [10:0] MON_MASK_2048 = 11'h7FF;

	typedef enum logic [2:0] {
		MON_OFF, MON_CONT, MON_32, MON_256, MON_2048
	} monitor_mode_e;

	// Settings driven to the analog macros
	typedef struct packed {
		logic [3:0] monitor_threshold;
		logic [3:0] lcd_regulator_level;
		logic [1:0] lcd_supply_select;
		logic brownout_disable;
		logic internal_regulator_used;
		logic backup_por_enable;
		logic osc_bypass_a;
	} analog_ctl_s;

	// Debounce length of a three-bit period code
	function automatic logic [15:0] debounce_limit(input logic [2:0] code);
		case (code)
			3'h1: debounce_limit = DBC_1;
			3'h2: debounce_limit = DBC_2;
			3'h3: debounce_limit = DBC_3;
			3'h4: debounce_limit = DBC_4;
			3'h5: debounce_limit = DBC_5;
			default: debounce_limit = 16'h0001;
		endcase
	endfunction
endpackage

// ===== hdl/wake_filter.sv
/*
 Level debouncer: fires once after the input stays active for a
 number of sampling ticks. Assumes tick_i is a one-cycle pulse.
*/
module wake_filter (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic tick_i,
	input wire logic active_i,
	input wire logic [15:0] limit_i,
	output logic fire_o
);
	logic [15:0] count_ff;
	logic done_ff;
	logic fire_ff;
	logic [15:0] nxt_count;

	assign nxt_count = count_ff + 16'h0001;
	assign fire_o = fire_ff;

	// ---------------------------------------------------------------
	// Count ticks while active, fire once, rearm when inactive
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_ff <= 16'h0000;
			done_ff <= 1'b0;
			fire_ff <= 1'b0;
		end else begin
			fire_ff <= 1'b0;
			if (!active_i) begin
				count_ff <= 16'h0000;
				done_ff <= 1'b0;
			end else if (tick_i && !done_ff) begin
				count_ff <= nxt_count;
				if (nxt_count >= limit_i) begin
					fire_ff <= 1'b1;
					done_ff <= 1'b1;
				end
			end
		end
	end

	property p_fire_needs_active;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		fire_o |-> $past(active_i) && $past(tick_i);
	endproperty
	a_fire_needs_active: assert property (p_fire_needs_active)
		else $error("filter fired without an active tick");
endmodule

// ===== test/test_supply_controller_regs.sv
/*
 Self-checking bench for the supply controller register block.
 Assumes the package and the design files are compiled before it.
*/
module test_supply_controller_regs;
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// Signals and instance
	// ---------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic wp = 1'b0;
	logic tick = 1'b0;
	logic mon_det = 1'b0;
	logic bod_det = 1'b0;
	logic bpor_st = 1'b0;
	logic fwake_n = 1'b1;
	logic [15:0] wpins = 16'h0000;
	logic rtc = 1'b0;
	logic [31:0] rdata;
	supply_pkg::analog_ctl_s actl;
	logic mon_en, vreg_off, xtal, settled, sys_rst, irq, wake, clr;
	int bad_count = 0;
	int n_tests = 0;
	int cnt;
	logic [1:0] tcnt = 2'h0;
	logic [31:0] d, got, mv, pv, e;

	supply_controller_regs dut (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr_s),
		.reg_rd_i(rd_s),
		.reg_rdata_o(rdata),
		.write_protect_enable_i(wp),
		.slow_clock_tick_i(tick),
		.monitor_detect_i(mon_det),
		.brownout_detect_i(bod_det),
		.backup_por_state_i(bpor_st),
		.force_wake_n_i(fwake_n),
		.wake_pins_i(wpins),
		.rtc_pulse_out_i(rtc),
		.analog_ctl_o(actl),
		.monitor_enable_o(mon_en),
		.regulator_off_o(vreg_off),
		.crystal_select_o(xtal),
		.backup_por_settled_o(settled),
		.system_reset_o(sys_rst),
		.irq_o(irq),
		.wakeup_o(wake),
		.backup_regs_clear_o(clr)
	);

	// Clock and a slow-clock tick every fourth cycle
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end

	// ---------------------------------------------------------------
	// Expectations, bus cycles and compares
	// ---------------------------------------------------------------
	function automatic logic [31:0] exp_rw(input logic [31:0] o,
			input logic [31:0] w, input logic [31:0] m);
		exp_rw = (o & ~m) | (w & m);
	endfunction

	function automatic supply_pkg::analog_ctl_s exp_actl(
			input logic [31:0] m, input logic [31:0] p, input logic x);
		exp_actl = {m[3:0], p[3:0], p[5:4], p[13], p[14], p[15], p[20] & x};
	endfunction

	task automatic end_sim();
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk32(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	// Watches an output for a bounded number of cycles
	task automatic ev(input int w, input int lim, input logic x);
		logic s;
		s = 1'b0;
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_sys_i);
			#1;
			s = s | ((w == 0 ? sys_rst : w == 1 ? wake :
				w == 2 ? irq : w == 3 ? mon_en : clr) === 1'b1);
		end
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch at %0t: event %0d seen %b", $time, w, s);
			if (x) end_sim();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_i);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_sys_i);
		wr_s <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys_i);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'hECA5));
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		// Reset values, write-only and unmapped places
		for (int a = 0; a <= 8'h18; a += 4) begin
			rd(a[7:0], got);
			chk32(got, a == 8 ? supply_pkg::RST_POWER : 32'h0);
		end
		wr(supply_pkg::OFF_STATUS, 32'hFFFF_FFFF);
		rd(supply_pkg::OFF_STATUS, got);
		chk32(got, 32'h0);
		wr(supply_pkg::OFF_COMMAND, 32'h5A00_000C);
		chk32({30'h0, sys_rst, xtal}, 32'h0);
		ev(0, 4, 1'b0);
		mv = 32'h0;
		pv = supply_pkg::RST_POWER;
		chk32({18'h0, actl}, {18'h0, exp_actl(mv, pv, 1'b0)});
		// Random setups, every LCD code, then a wrongly keyed write
		for (int i = 0; i < 8; i++) begin
			d = $urandom();
			wr(supply_pkg::OFF_MONITOR, d);
			rd(supply_pkg::OFF_MONITOR, mv);
			chk32(mv, exp_rw(32'h0, d, supply_pkg::MASK_MONITOR));
			d = $urandom();
			d[31:24] = supply_pkg::KEY_VALUE;
			d[5:4] = i[1:0];
			wr(supply_pkg::OFF_POWER, d);
			rd(supply_pkg::OFF_POWER, pv);
			chk32(pv, exp_rw(supply_pkg::RST_POWER, d, supply_pkg::MASK_POWER));
			chk32({18'h0, actl}, {18'h0, exp_actl(mv, pv, 1'b0)});
			wr(supply_pkg::OFF_POWER, {8'h5A, ~d[23:0]});
			rd(supply_pkg::OFF_POWER, got);
			chk32(got, pv);
		end
		// Backup reset enable against its live state
		for (int i = 0; i < 4; i++) begin
			wr(supply_pkg::OFF_POWER, {16'hA500, i[0], 15'h4000});
			@(posedge clk_sys_i);
			bpor_st <= i[1];
			@(posedge clk_sys_i);
			#1;
			chk32({31'h0, settled}, {31'h0, i[0] == i[1]});
		end
		// Write protect blocks the setup registers and commands
		wr(supply_pkg::OFF_MONITOR, 32'h0);
		wr(supply_pkg::OFF_POWER, 32'hA500_4000);
		@(posedge clk_sys_i);
		wp <= 1'b1;
		for (int a = 4; a <= 8'h0C; a += 4) begin
			wr(a[7:0], 32'hA5FF_FFFF);
			rd(a[7:0], got);
			e = exp_rw(supply_pkg::RST_POWER, 32'hA500_4000, supply_pkg::MASK_POWER);
			chk32(got, a == 8 ? e : 32'h0);
		end
		wr(supply_pkg::OFF_COMMAND, 32'hA500_0008);
		chk32({31'h0, xtal}, 32'h0);
		wr(supply_pkg::OFF_WAKE_PIN, 32'h0001_0001);
		rd(supply_pkg::OFF_WAKE_PIN, got);
		chk32(got, 32'h0001_0001);
		@(posedge clk_sys_i);
		wp <= 1'b0;
		// Brownout: enabled, reset disabled, detector off
		for (int k = 0; k < 3; k++) begin
			wr(supply_pkg::OFF_POWER, k == 0 ? 32'hA500_5000 :
				k == 1 ? 32'hA500_4000 : 32'hA500_7000);
			@(posedge clk_sys_i);
			bod_det <= 1'b1;
			ev(0, 4, k == 0);
			@(posedge clk_sys_i);
			bod_det <= 1'b0;
		end
		// Monitor: detection without and with reset and interrupt
		for (int k = 0; k < 2; k++) begin
			wr(supply_pkg::OFF_MONITOR, k == 0 ? 32'h0100 : 32'h3100);
			ev(3, 4, 1'b1);
			@(posedge clk_sys_i);
			mon_det <= 1'b1;
			ev(0, 4, k == 1);
			ev(2, 2, k == 1);
			@(posedge clk_sys_i);
			mon_det <= 1'b0;
			rd(supply_pkg::OFF_STATUS, got);
			chk32({31'h0, got[1]}, 32'h1);
		end
		wr(supply_pkg::OFF_MONITOR, 32'h3000);
		repeat (2) @(posedge clk_sys_i);
		mon_det <= 1'b1;
		ev(3, 4, 1'b0);
		@(posedge clk_sys_i);
		mon_det <= 1'b0;
		// Windowed monitor: one tick period in 32, four clocks a tick
		wr(supply_pkg::OFF_MONITOR, 32'h0200);
		repeat (8) @(posedge clk_sys_i);
		cnt = 0;
		repeat (256) begin
			@(posedge clk_sys_i);
			#1;
			cnt += mon_en;
		end
		chk32(cnt, 32'h8);
		// Force wake: immediate, disabled, three-period debounce
		wr(supply_pkg::OFF_WAKE_PIN, 32'h0);
		for (int k = 0; k < 3; k++) begin
			wr(supply_pkg::OFF_WAKE_SRC, k == 0 ? 32'h1 : k == 1 ? 32'h0 : 32'h101);
			@(posedge clk_sys_i);
			fwake_n <= 1'b0;
			if (k == 2) ev(1, 6, 1'b0);
			ev(1, 16, k != 1);
			@(posedge clk_sys_i);
			fwake_n <= 1'b1;
		end
		// Wake pin 3 held high: high level active, then low selected
		wr(supply_pkg::OFF_WAKE_SRC, 32'h1000);
		@(posedge clk_sys_i);
		wpins <= 16'h0008;
		for (int k = 0; k < 2; k++) begin
			wr(supply_pkg::OFF_WAKE_PIN,
				k == 0 ? 32'h0008_0008 : 32'h0000_0008);
			if (k == 0) ev(1, 6, 1'b0);
			ev(1, 16, k == 0);
			rd(supply_pkg::OFF_STATUS, got);
			chk32({31'h0, got[2]}, {31'h0, k == 0});
		end
		// Tamper pin 0 low, two RTC samples, clear on; then count zero
		for (int k = 0; k < 2; k++) begin
			wr(supply_pkg::OFF_WAKE_SRC,
				k == 0 ? 32'h0001_00A0 : 32'h0000_00A0);
			repeat (2) begin
				@(posedge clk_sys_i);
				rtc <= 1'b1;
				@(posedge clk_sys_i);
				rtc <= 1'b0;
			end
			ev(4, 3, k == 0);
		end
		// Commands: bypass then crystal select, then regulator off
		wr(supply_pkg::OFF_POWER, 32'hA510_4000);
		chk32({31'h0, actl.osc_bypass_a}, 32'h0);
		wr(supply_pkg::OFF_COMMAND, 32'hA500_0008);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk32({30'h0, xtal, actl.osc_bypass_a}, 32'h3);
		chk32({31'h0, vreg_off}, 32'h0);
		wr(supply_pkg::OFF_COMMAND, 32'hA500_0004);
		chk32({30'h0, sys_rst, vreg_off}, 32'h3);
		ev(0, 3, 1'b0);
		chk32({31'h0, vreg_off}, 32'h1);
		end_sim();
	end
endmodule
